// >>> ocd_pkg.sv
// shared constants and carrier types for the output clock divider pair
package ocd_pkg;
	// register indices; byte address is four times the index
	localparam logic [9:0] OCD_IDX_DIV0_COUNTS = 10'h190;
	localparam logic [9:0] OCD_IDX_DIV0_CTRL = 10'h191;
	localparam logic [9:0] OCD_IDX_DIV0_ROUTE = 10'h192;
	localparam logic [9:0] OCD_IDX_DIV1_COUNTS = 10'h193;
	localparam logic [9:0] OCD_IDX_DIV1_CTRL = 10'h194;
	localparam logic [9:0] OCD_IDX_SRC_SEL = 10'h1e1;
	localparam logic [9:0] OCD_IDX_STATUS = 10'h1e2;
	localparam int OCD_ADDR_W = 12;
	// field positions
	localparam int OCD_LOW_MSB = 7;
	localparam int OCD_LOW_LSB = 4;
	localparam int OCD_HIGH_MSB = 3;
	localparam int OCD_HIGH_LSB = 0;
	localparam int OCD_BYPASS_BIT = 7;
	localparam int OCD_NOSYNC_BIT = 6;
	localparam int OCD_FORCE_BIT = 5;
	localparam int OCD_START_BIT = 4;
	localparam int OCD_PHASE_MSB = 3;
	localparam int OCD_PHASE_LSB = 0;
	localparam int OCD_DIRECT_BIT = 1;
	localparam int OCD_DCC_OFF_BIT = 0;
	// reset values
	localparam logic [7:0] OCD_RST_COUNTS = 8'h00;
	localparam logic [7:0] OCD_RST_DIV0_CTRL = 8'h80;
	localparam logic [7:0] OCD_RST_DIV1_CTRL = 8'h00;
	localparam logic [7:0] OCD_RST_ROUTE = 8'h00;
	localparam logic [1:0] OCD_RST_SRC_SEL = 2'h0;
	// global source selector encodings
	localparam logic [1:0] OCD_SRC_EXT = 2'h0;
	localparam logic [1:0] OCD_SRC_DIV = 2'h1;
	localparam logic [1:0] OCD_SRC_OSC = 2'h2;
	// axi responses
	localparam logic [1:0] OCD_RESP_OKAY = 2'h0;
	localparam logic [1:0] OCD_RESP_SLVERR = 2'h2;
	// divider sequencer states, gray along hold -> phase -> run
	typedef enum logic [1:0] {
		OCD_ST_HOLD = 2'b00,
		OCD_ST_PHASE = 2'b01,
		OCD_ST_RUN = 2'b11
	} ocd_state_e;
	// one divider's settings
	typedef struct packed {
		logic [3:0] low_cnt;
		logic [3:0] high_cnt;
		logic bypass;
		logic nosync;
		logic force_high;
		logic start_high;
		logic [3:0] phase;
	} ocd_div_cfg_s;
endpackage

// >>> ocd_divider.sv
// one programmable integer divider with sync restart, phase offset and forcing
`timescale 1ns/1ps
module ocd_divider (
	input wire logic clk,
	input wire logic rst_n,
	input ocd_pkg::ocd_div_cfg_s cfg,
	input wire logic chip_sync,
	output logic div_out,
	output logic running
);
	import ocd_pkg::*;

	ocd_state_e st_r;
	logic [3:0] cnt_r;
	logic q_r;
	logic sync_hit;
	logic toggle;

	// sync is honoured only when the divider is not told to ignore it
	assign sync_hit = chip_sync && !cfg.nosync;
	assign toggle = (st_r == OCD_ST_RUN) && (cnt_r == 4'h0);
	assign running = (st_r == OCD_ST_RUN);

	// sequencer and counter; bypass parks the sequencer in hold with the counter cleared, acting as power-down
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= OCD_ST_HOLD;
			cnt_r <= 4'h0;
			q_r <= 1'b0;
		end else if (cfg.bypass) begin
			st_r <= OCD_ST_HOLD; // R04
			cnt_r <= 4'h0;
		end else if (sync_hit) begin
			st_r <= OCD_ST_HOLD; // R06
			cnt_r <= 4'h0;
			q_r <= cfg.start_high; // R08
		end else if (chip_sync && cfg.nosync) begin
			q_r <= cfg.force_high; // R07
		end else begin
			case (st_r)
				OCD_ST_HOLD: begin
					q_r <= cfg.start_high; // R15
					cnt_r <= cfg.phase; // R09
					st_r <= (cfg.phase == 4'h0) ? OCD_ST_RUN : OCD_ST_PHASE;
					if (cfg.phase == 4'h0) begin
						cnt_r <= cfg.start_high ? cfg.high_cnt : cfg.low_cnt;
					end
				end
				OCD_ST_PHASE: begin
					// start level waits out the phase offset
					if (cnt_r == 4'h1) begin
						st_r <= OCD_ST_RUN; // R15
						cnt_r <= q_r ? cfg.high_cnt : cfg.low_cnt;
					end else begin
						cnt_r <= cnt_r - 4'h1;
					end
				end
				OCD_ST_RUN: begin
					if (toggle) begin
						q_r <= !q_r;
						cnt_r <= q_r ? cfg.low_cnt : cfg.high_cnt; // R01 R02
					end else begin
						cnt_r <= cnt_r - 4'h1;
					end
				end
				default: begin
					st_r <= OCD_ST_HOLD;
				end
			endcase
		end
	end

	// clock mux: bypass passes the input clock straight through, glitchy on switch
	assign div_out = cfg.bypass ? clk : q_r; // R04

	// length of the current output level, for checking only
	// seg_r keeps the count loaded at the last reload, since a mid-level write moves cfg
	logic [4:0] len_r;
	logic clean_r;
	logic [3:0] seg_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			len_r <= 5'h0;
			clean_r <= 1'b0;
			seg_r <= 4'h0;
		end else if (st_r != OCD_ST_RUN || cfg.bypass || chip_sync) begin
			len_r <= 5'h1;
			clean_r <= 1'b0;
		end else if (toggle) begin
			len_r <= 5'h1;
			clean_r <= 1'b1;
			seg_r <= q_r ? cfg.low_cnt : cfg.high_cnt;
		end else begin
			len_r <= len_r + 5'h1;
		end
	end

	low_len_a: assert property (@(posedge clk) disable iff (!rst_n) // R01
		toggle && clean_r && !q_r && !cfg.bypass && !chip_sync
		|-> len_r == {1'b0, seg_r} + 5'h1)
		else $error("low level length wrong");
	high_len_a: assert property (@(posedge clk) disable iff (!rst_n) // R02
		toggle && clean_r && q_r && !cfg.bypass && !chip_sync
		|-> len_r == {1'b0, seg_r} + 5'h1)
		else $error("high level length wrong");
	bypass_pd_a: assert property (@(posedge clk) disable iff (!rst_n) // R04
		cfg.bypass |=> st_r == OCD_ST_HOLD && cnt_r == 4'h0)
		else $error("counters run in bypass");
	sync_obey_a: assert property (@(posedge clk) disable iff (!rst_n) // R06
		sync_hit && !cfg.bypass |=> st_r == OCD_ST_HOLD)
		else $error("sync not obeyed");
	sync_ignore_a: assert property (@(posedge clk) disable iff (!rst_n) // R06
		chip_sync && cfg.nosync && !cfg.bypass && st_r == OCD_ST_RUN |=> st_r == OCD_ST_RUN)
		else $error("sync not ignored");
	force_lvl_a: assert property (@(posedge clk) disable iff (!rst_n) // R07
		chip_sync && cfg.nosync && !cfg.bypass |=> q_r == $past(cfg.force_high))
		else $error("forced level wrong");
	start_lvl_a: assert property (@(posedge clk) disable iff (!rst_n) // R08
		sync_hit && !cfg.bypass ##1 !chip_sync && !cfg.bypass |=> q_r == $past(cfg.start_high, 2))
		else $error("start level wrong");
	phase_dly_a: assert property (@(posedge clk) disable iff (!rst_n) // R15
		st_r == OCD_ST_HOLD && !chip_sync && !cfg.bypass && cfg.phase == 4'h2 && $stable(cfg)
		|=> st_r == OCD_ST_PHASE ##1 st_r == OCD_ST_PHASE ##1 st_r == OCD_ST_RUN)
		else $error("phase offset delay wrong");
endmodule // ocd_divider

// >>> ocd_top.sv
// register file, axi4-lite slave and output routing for the first two dividers
//
// Behaviour
// R01: low time is low-count field plus one input cycles; zero means one cycle.
// R02: high time is high-count field plus one input cycles; fields reset to zero.
// R03: second divider's low-count field uses the same plus-one encoding.
// R04: bypass powers down counters and passes the input clock to the output.
// R05: first divider resets bypassed, second resets dividing.
// R06: no-sync clear obeys chip sync; set ignores it.
// R07: force bit sets static output level; software must also set no-sync.
// R08: start-high bit picks initial output level when counting begins.
// R09: four-bit phase offset per divider shifts the starting phase, resets zero.
// R10: direct bit clear feeds both pair outputs from the first divider.
// R11: direct bit set and selector 10b routes oscillator to both outputs.
// R12: direct bit set and selector 00b routes external clock to both outputs.
// R13: selector 01b makes the direct bit have no effect.
// R14: duty correction enabled when its bit is zero, disabled when one.
// R15: period is low plus high; honoured sync restarts from start level after offset.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module ocd_top (
	input wire logic clk,
	input wire logic rst_n,
	// axi4-lite write address
	input wire logic [ocd_pkg::OCD_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [ocd_pkg::OCD_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// clock sources and chip-level sync
	input wire logic chip_sync,
	input wire logic internal_oscillator,
	input wire logic ext_clk,
	// output pairs
	output logic pair0_output_a,
	output logic pair0_output_b,
	output logic pair1_output_a,
	output logic pair1_output_b,
	// duty correction controls toward the output drivers
	output logic pair0_duty_correction_disable,
	output logic pair1_duty_correction_disable
);
	import ocd_pkg::*;

	// word index of an aligned byte address
	function automatic logic [9:0] word_idx(input logic [OCD_ADDR_W-1:0] addr);
		word_idx = addr[OCD_ADDR_W-1:2];
	endfunction

	// true when the address hits a mapped register
	function automatic logic is_mapped(input logic [OCD_ADDR_W-1:0] addr);
		logic [9:0] idx;
		idx = word_idx(addr);
		is_mapped = (addr[1:0] == 2'h0) &&
			(idx == OCD_IDX_DIV0_COUNTS || idx == OCD_IDX_DIV0_CTRL ||
			idx == OCD_IDX_DIV0_ROUTE || idx == OCD_IDX_DIV1_COUNTS ||
			idx == OCD_IDX_DIV1_CTRL || idx == OCD_IDX_SRC_SEL ||
			idx == OCD_IDX_STATUS);
	endfunction

	// unpack a count/control register pair into divider settings
	function automatic ocd_div_cfg_s make_cfg(input logic [7:0] counts, input logic [7:0] ctrl);
		ocd_div_cfg_s c;
		c.low_cnt = counts[OCD_LOW_MSB:OCD_LOW_LSB];
		c.high_cnt = counts[OCD_HIGH_MSB:OCD_HIGH_LSB];
		c.bypass = ctrl[OCD_BYPASS_BIT];
		c.nosync = ctrl[OCD_NOSYNC_BIT];
		c.force_high = ctrl[OCD_FORCE_BIT];
		c.start_high = ctrl[OCD_START_BIT];
		c.phase = ctrl[OCD_PHASE_MSB:OCD_PHASE_LSB];
		make_cfg = c;
	endfunction

	logic [7:0] div0_cycle_counts_r;
	logic [7:0] div0_control_r;
	logic [7:0] div0_routing_r;
	logic [7:0] div1_cycle_counts_r;
	logic [7:0] div1_control_r;
	logic [1:0] src_sel_r;

	logic aw_hold_r;
	logic [OCD_ADDR_W-1:0] awaddr_r;
	logic w_hold_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic wr_go;
	logic [9:0] wr_idx;
	logic wr_lane0;

	ocd_div_cfg_s div0_cfg;
	ocd_div_cfg_s div1_cfg;
	logic div0_out;
	logic div1_out;
	logic div0_running;
	logic div1_running;
	logic direct_en;
	logic pair0_src;

	// handshake readies; each channel is taken once and held until the response
	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready = !w_hold_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// write fires once both address and data have been taken
	assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
	assign wr_idx = word_idx(awaddr_r);
	assign wr_lane0 = wstrb_r[0];

	// capture write address and data in either order
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_hold_r <= 1'b0;
			awaddr_r <= '0;
			w_hold_r <= 1'b0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_hold_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end else if (wr_go) begin
				w_hold_r <= 1'b0;
			end
		end
	end

	// write response one cycle after both halves are in
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_r <= 1'b0;
			bresp_r <= OCD_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r <= is_mapped(awaddr_r) ? OCD_RESP_OKAY : OCD_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// register writes; only byte lane 0 carries data, status is read only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div0_cycle_counts_r <= OCD_RST_COUNTS; // R02
			div0_control_r <= OCD_RST_DIV0_CTRL; // R05
			div0_routing_r <= OCD_RST_ROUTE;
			div1_cycle_counts_r <= OCD_RST_COUNTS;
			div1_control_r <= OCD_RST_DIV1_CTRL; // R05
			src_sel_r <= OCD_RST_SRC_SEL;
		end else if (wr_go && wr_lane0 && awaddr_r[1:0] == 2'h0) begin
			case (wr_idx)
				OCD_IDX_DIV0_COUNTS: div0_cycle_counts_r <= wdata_r[7:0];
				OCD_IDX_DIV0_CTRL: div0_control_r <= wdata_r[7:0];
				OCD_IDX_DIV0_ROUTE: div0_routing_r <= wdata_r[7:0] & 8'h03;
				OCD_IDX_DIV1_COUNTS: div1_cycle_counts_r <= wdata_r[7:0];
				OCD_IDX_DIV1_CTRL: div1_control_r <= wdata_r[7:0];
				OCD_IDX_SRC_SEL: src_sel_r <= wdata_r[1:0];
				default: begin
				end
			endcase
		end
	end

	// read data registered; unmapped reads return zero with slverr
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= OCD_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rresp_r <= is_mapped(s_axi_araddr) ? OCD_RESP_OKAY : OCD_RESP_SLVERR;
			rdata_r <= 32'h0;
			if (s_axi_araddr[1:0] == 2'h0) begin
				case (word_idx(s_axi_araddr))
					OCD_IDX_DIV0_COUNTS: rdata_r <= {24'h0, div0_cycle_counts_r};
					OCD_IDX_DIV0_CTRL: rdata_r <= {24'h0, div0_control_r};
					OCD_IDX_DIV0_ROUTE: rdata_r <= {24'h0, div0_routing_r};
					OCD_IDX_DIV1_COUNTS: rdata_r <= {24'h0, div1_cycle_counts_r};
					OCD_IDX_DIV1_CTRL: rdata_r <= {24'h0, div1_control_r};
					OCD_IDX_SRC_SEL: rdata_r <= {30'h0, src_sel_r};
					// live divider state so software can see counting
					OCD_IDX_STATUS: rdata_r <= {28'h0, div1_running, div0_running,
						div1_cfg.bypass ? 1'b0 : div1_out,
						div0_cfg.bypass ? 1'b0 : div0_out};
					default: rdata_r <= 32'h0;
				endcase
			end
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// settings into each divider; both share one decode of the fields
	assign div0_cfg = make_cfg(div0_cycle_counts_r, div0_control_r); // R01 R09
	assign div1_cfg = make_cfg(div1_cycle_counts_r, div1_control_r); // R03

	ocd_divider u_div0 (
		.clk(clk),
		.rst_n(rst_n),
		.cfg(div0_cfg),
		.chip_sync(chip_sync),
		.div_out(div0_out),
		.running(div0_running)
	);

	ocd_divider u_div1 (
		.clk(clk),
		.rst_n(rst_n),
		.cfg(div1_cfg),
		.chip_sync(chip_sync),
		.div_out(div1_out),
		.running(div1_running)
	);

	// direct path: a clock mux, so switching sources may glitch the pair
	assign direct_en = div0_routing_r[OCD_DIRECT_BIT];
	always_comb begin
		pair0_src = div0_out; // R10 R13
		if (direct_en && src_sel_r == OCD_SRC_OSC) begin
			pair0_src = internal_oscillator; // R11
		end else if (direct_en && src_sel_r == OCD_SRC_EXT) begin
			pair0_src = ext_clk; // R12
		end
	end
	assign pair0_output_a = pair0_src;
	assign pair0_output_b = pair0_src;
	assign pair1_output_a = div1_out;
	assign pair1_output_b = div1_out;

	// correction itself lives in the analog driver; only the control is carried
	assign pair0_duty_correction_disable = div0_routing_r[OCD_DCC_OFF_BIT]; // R14
	assign pair1_duty_correction_disable = 1'b0; // R14

	// first cycle after reset, for checking reset values
	logic first_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			first_r <= 1'b1;
		end else begin
			first_r <= 1'b0;
		end
	end

	reset_bypass_a: assert property (@(posedge clk) disable iff (!rst_n) // R05
		first_r |-> div0_control_r[OCD_BYPASS_BIT] && !div1_control_r[OCD_BYPASS_BIT])
		else $error("bypass reset values wrong");
	route_div_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
		!direct_en |-> pair0_output_a == div0_out && pair0_output_b == div0_out)
		else $error("pair not fed from divider");
	route_osc_a: assert property (@(posedge clk) disable iff (!rst_n) // R11
		direct_en && src_sel_r == OCD_SRC_OSC |-> pair0_output_a == internal_oscillator
		&& pair0_output_b == internal_oscillator)
		else $error("oscillator not routed");
	route_ext_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
		direct_en && src_sel_r == OCD_SRC_EXT |-> pair0_output_a == ext_clk)
		else $error("external clock not routed");
	route_noeff_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
		src_sel_r == OCD_SRC_DIV |-> pair0_output_b == div0_out)
		else $error("direct bit acted with divider source");
	dcc_ctrl_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
		wr_go && wr_lane0 && awaddr_r[1:0] == 2'h0 && wr_idx == OCD_IDX_DIV0_ROUTE
		|=> pair0_duty_correction_disable == $past(wdata_r[OCD_DCC_OFF_BIT]))
		else $error("duty correction control wrong");
	div1_low_a: assert property (@(posedge clk) disable iff (!rst_n) // R03
		u_div1.toggle && u_div1.q_r && !div1_cfg.bypass && !chip_sync
		|=> u_div1.cnt_r == $past(div1_cycle_counts_r[OCD_LOW_MSB:OCD_LOW_LSB]))
		else $error("second divider low field misdecoded");
	write_resp_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_go |=> s_axi_bvalid ##0 $past(aw_hold_r && w_hold_r))
		else $error("write response missing");
endmodule // ocd_top

// >>> ocd_top_tb.sv
// self-checking testbench for the output clock divider pair
`timescale 1ns/1ps
`define check(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module ocd_top_tb;
	import ocd_pkg::*;
	logic clk, rst_n, chip_sync, internal_oscillator, ext_clk;
	logic [OCD_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic pair0_output_a, pair0_output_b, pair1_output_a, pair1_output_b;
	logic pair0_duty_correction_disable, pair1_duty_correction_disable;
	int miscompares, comparisons;
	logic [7:0] model [int];

	ocd_top DUT (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .chip_sync(chip_sync),
		.internal_oscillator(internal_oscillator), .ext_clk(ext_clk),
		.pair0_output_a(pair0_output_a), .pair0_output_b(pair0_output_b),
		.pair1_output_a(pair1_output_a), .pair1_output_b(pair1_output_b),
		.pair0_duty_correction_disable(pair0_duty_correction_disable),
		.pair1_duty_correction_disable(pair1_duty_correction_disable));

	// 50 mhz divider input clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// verdict, printed in one place only
	task automatic finish_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// write: address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// no cycle limit here: a hang is ended by the watchdog
		do begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready));
		`check(s_axi_bvalid, 1'b1)
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// read: data and response taken at the edge where rvalid is seen
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready));
		`check(s_axi_rvalid, 1'b1)
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// register access that keeps the bench model in step
	task automatic reg_wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic [1:0] resp;
		axi_wr({idx, 2'b00}, {24'h0, d}, resp);
		`check(resp, er)
		if (er === OCD_RESP_OKAY) begin
			model[idx] = (idx == OCD_IDX_DIV0_ROUTE || idx == OCD_IDX_SRC_SEL) ? (d & 8'h03) : d;
		end
	endtask

	task automatic reg_rd(input logic [9:0] idx, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] resp;
		axi_rd({idx, 2'b00}, d, resp);
		`check(resp, er)
		`check(d, (er === OCD_RESP_OKAY) ? {24'h0, model[idx]} : 32'h0)
	endtask

	task automatic read_all;
		int idx [6] = '{OCD_IDX_DIV0_COUNTS, OCD_IDX_DIV0_CTRL, OCD_IDX_DIV0_ROUTE,
			OCD_IDX_DIV1_COUNTS, OCD_IDX_DIV1_CTRL, OCD_IDX_SRC_SEL};
		foreach (idx[i]) reg_rd(idx[i][9:0], OCD_RESP_OKAY);
	endtask

	// program one divider, sync it, then measure the runs of its output
	task automatic div_run(input int d, input logic [7:0] cnt, input logic [7:0] ctrl,
		output int first);
		logic s [80];
		int i, r1, r2;
		logic st;
		reg_wr(d ? OCD_IDX_DIV1_COUNTS : OCD_IDX_DIV0_COUNTS, cnt, OCD_RESP_OKAY);
		reg_wr(d ? OCD_IDX_DIV1_CTRL : OCD_IDX_DIV0_CTRL, ctrl, OCD_RESP_OKAY);
		st = ctrl[OCD_START_BIT];
		@(posedge clk);
		chip_sync <= 1'b1;
		repeat (3) @(negedge clk);
		`check(d ? pair1_output_a : pair0_output_a, st)
		@(posedge clk);
		chip_sync <= 1'b0;
		for (i = 0; i < 80; i++) begin
			@(negedge clk);
			#1;
			s[i] = d ? pair1_output_a : pair0_output_a;
			`check(d ? pair1_output_b : pair0_output_b, s[i])
		end
		`check(s[0], st)
		first = 1;
		while (first < 80 && s[first] === st) first++;
		r1 = 0;
		for (i = first; i < 80 && s[i] === !st; i++) r1++;
		r2 = 0;
		for (; i < 80 && s[i] === st; i++) r2++;
		`check(r1, st ? cnt[7:4] + 1 : cnt[3:0] + 1)
		`check(r2, st ? cnt[3:0] + 1 : cnt[7:4] + 1)
	endtask

	// watchdog at 20000 cycles, far beyond the expected thousand or so
	initial begin
		#400000;
		miscompares++;
		finish_test();
	end

	// main sequence
	initial begin
		int f0, fp, p, sel, dir, dcc;
		logic [7:0] cnt;
		logic st, e;
		logic [1:0] rsp;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{chip_sync, internal_oscillator, ext_clk} = '0;
		rst_n = 1'b0;
		void'($urandom(32'hfb68ce5b));
		model[OCD_IDX_DIV0_COUNTS] = OCD_RST_COUNTS;
		model[OCD_IDX_DIV0_CTRL] = OCD_RST_DIV0_CTRL;
		model[OCD_IDX_DIV0_ROUTE] = OCD_RST_ROUTE;
		model[OCD_IDX_DIV1_COUNTS] = OCD_RST_COUNTS;
		model[OCD_IDX_DIV1_CTRL] = OCD_RST_DIV1_CTRL;
		model[OCD_IDX_SRC_SEL] = {6'h0, OCD_RST_SRC_SEL};
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		// reset values and the bypassed first divider following the clock
		read_all();
		@(negedge clk);
		#1;
		`check(pair0_output_a, 1'b0)
		@(posedge clk);
		#1;
		`check(pair0_output_a, 1'b1)
		$display("test reset values done");
		// unmapped and unaligned places are refused and change nothing
		reg_wr(10'h0ff, 8'h5a, OCD_RESP_SLVERR);
		axi_wr(12'h641, 32'ha5, rsp);
		`check(rsp, OCD_RESP_SLVERR)
		reg_rd(10'h0ff, OCD_RESP_SLVERR);
		read_all();
		$display("test refused access done");
		// both dividers, random counts, with and without a phase offset
		for (int d = 0; d < 2; d++) begin
			for (int k = 0; k < 2; k++) begin
				cnt = 8'($urandom);
				st = 1'($urandom);
				// a fixed offset of two once per divider exercises the phase assertion
				p = k ? $urandom_range(15, 1) : 2;
				div_run(d, cnt, {3'b000, st, 4'h0}, f0);
				div_run(d, cnt, {3'b000, st, 4'(p)}, fp);
				`check(fp - f0, p)
			end
		end
		read_all();
		$display("test divider timing done");
		// forced level needs no-sync set; sync is ignored meanwhile
		for (int f = 0; f < 2; f++) begin
			reg_wr(OCD_IDX_DIV1_CTRL, {2'b01, 1'(f), 5'h10}, OCD_RESP_OKAY);
			@(posedge clk);
			chip_sync <= 1'b1;
			repeat (2) @(negedge clk);
			`check(pair1_output_a, 1'(f))
			@(posedge clk);
			chip_sync <= 1'b0;
		end
		$display("test force done");
		// bypass passes the input clock straight through
		reg_wr(OCD_IDX_DIV1_CTRL, 8'h80, OCD_RESP_OKAY);
		@(negedge clk);
		#1;
		`check(pair1_output_a, 1'b0)
		@(posedge clk);
		#1;
		`check(pair1_output_a, 1'b1)
		$display("test bypass done");
		// direct routing for every selector code, then with the direct bit clear
		reg_wr(OCD_IDX_DIV0_CTRL, 8'h80, OCD_RESP_OKAY);
		for (int r = 0; r < 5; r++) begin
			dir = (r < 4) ? 1 : 0;
			sel = (r < 4) ? r : 2;
			dcc = $urandom_range(1, 0);
			reg_wr(OCD_IDX_DIV0_ROUTE, {6'h0, 1'(dir), 1'(dcc)}, OCD_RESP_OKAY);
			reg_wr(OCD_IDX_SRC_SEL, 8'(sel), OCD_RESP_OKAY);
			`check(pair0_duty_correction_disable, 1'(dcc))
			`check(pair1_duty_correction_disable, 1'b0)
			repeat (6) begin
				@(posedge clk);
				internal_oscillator <= 1'($urandom);
				ext_clk <= 1'($urandom);
				@(negedge clk);
				#1;
				// divider path is bypassed, so it shows the low clock phase
				e = (dir == 1 && sel == 2) ? internal_oscillator :
					(dir == 1 && sel == 0) ? ext_clk : 1'b0;
				`check(pair0_output_a, e)
				`check(pair0_output_b, e)
			end
		end
		read_all();
		// both dividers bypassed now, so status shows nothing running
		model[OCD_IDX_STATUS] = 8'h00;
		reg_rd(OCD_IDX_STATUS, OCD_RESP_OKAY);
		$display("test direct routing done");
		finish_test();
	end
endmodule // ocd_top_tb
